// *** inc/bbsw_pkg.sv ***
package bbsw_pkg;
	// sync vector bit positions
	localparam int IN_RUN  = 0; // shutdown_input, high = run
	localparam int IN_ABV  = 1; // output above threshold
	localparam int IN_VLO  = 2; // input 400 mV or more below output
	localparam int IN_VHI  = 3; // input 800 mV or more above output
	localparam int IN_PEAK = 4;
	localparam int IN_VAL  = 5;
	localparam int IN_ZERO = 6;
	localparam int IN_UP   = 7; // output above start-up threshold
	localparam int IN_OT   = 8; // over-temperature
	localparam int IN_W    = 9;
	// gate vector bit positions
	localparam int G_A = 3;
	localparam int G_B = 2;
	localparam int G_C = 1;
	localparam int G_D = 0;
	// timing
	localparam int CLK_MHZ       = 40;
	localparam int OFF_TIME_TIMER_FOUR_NS  = 3000;
	localparam int OFF_TIME_TIMER_START_NS = 800;
	localparam int OFF_TIME_TIMER_FOUR_CYC = (OFF_TIME_TIMER_FOUR_NS * CLK_MHZ + 999) / 1000;
	localparam int OFF_TIME_TIMER_START_CYC = (OFF_TIME_TIMER_START_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W = 8;
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int CTRL_EN     = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int STAT_SEQ    = 0;  // 3 bits
	localparam int STAT_MODE   = 4;  // 2 bits
	localparam int STAT_GATES  = 8;  // 4 bits, A B C D
	localparam int STAT_FLAGS  = 16; // 9 bits, synchronised inputs
	typedef enum logic [2:0] {
		SEQ_SLEEP,
		SEQ_START_ON,
		SEQ_START_OFF,
		SEQ_AC,
		SEQ_AD,
		SEQ_BD
	} seq_t;
	typedef enum logic [1:0] {
		MODE_START,
		MODE_BOOST,
		MODE_FOUR,
		MODE_BUCK
	} mode_t;
	typedef struct packed {
		logic [IN_W-1:0]  s1;
		logic [IN_W-1:0]  s2;
		seq_t             seq;
		mode_t            mode;
		logic [TMR_W-1:0] timer;
		logic [3:0]       gates;
		logic             enable;
		logic             ack;
		logic [31:0]      rdata;
	} core_t;
endpackage

// *** rtl/buck_boost_burst_switch_sequencer.sv ***
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module buck_boost_burst_switch_sequencer #(
	parameter logic [7:0] FOUR_OFF_CYC  = 8'(bbsw_pkg::OFF_TIME_TIMER_FOUR_CYC),
	parameter logic [7:0] START_OFF_CYC = 8'(bbsw_pkg::OFF_TIME_TIMER_START_CYC)
) (
	input  wire logic        ref_clk,          // 40 MHz clock
	input  wire logic        reset,            // async, active high
	input  wire logic        shutdownInput,    // low stops converter
	input  wire logic        outAboveFlag,     // output above reference
	input  wire logic        vinLowFlag,       // input well below output
	input  wire logic        vinHighFlag,      // input well above output
	input  wire logic        peakCurrentFlag,  // inductor at peak
	input  wire logic        valleyCurrentFlag,// inductor at valley
	input  wire logic        zeroCurrentFlag,  // inductor at zero
	input  wire logic        startupDoneFlag,  // output above 1.6 V
	input  wire logic        overTempFlag,     // die too hot
	input  wire logic        cyc_i,            // wishbone cycle
	input  wire logic        stb_i,            // wishbone strobe
	input  wire logic        we_i,             // wishbone write
	input  wire logic [3:0]  adr_i,            // byte address
	input  wire logic [31:0] dat_i,            // write data
	input  wire logic [3:0]  sel_i,            // byte selects
	output logic             ack_o,            // wishbone ack
	output logic      [31:0] dat_o,            // read data
	output logic             gateA,            // switch A on
	output logic             gateB,            // switch B on
	output logic             gateC,            // switch C on
	output logic             gateD             // switch D on
);

	bbsw_pkg::core_t st_r;
	bbsw_pkg::core_t st_nxt;
	logic [bbsw_pkg::IN_W-1:0] rawIn;
	logic [bbsw_pkg::IN_W-1:0] flg;
	logic [3:0] want;
	logic       run;
	logic       busReq;

	// pick the power stage from the two difference comparators
	function automatic bbsw_pkg::mode_t pickMode(
		input logic vLo,
		input logic vHi
	);
		if (vLo)
			pickMode = bbsw_pkg::MODE_BOOST;
		else if (vHi)
			pickMode = bbsw_pkg::MODE_BUCK;
		else
			pickMode = bbsw_pkg::MODE_FOUR;
	endfunction

	// break-before-make for one P/N pair: {hi, lo}
	function automatic logic [1:0] pairGate(
		input logic wantHi,
		input logic wantLo,
		input logic curHi,
		input logic curLo
	);
		pairGate[1] = wantHi & ~curLo;
		pairGate[0] = wantLo & ~wantHi & ~curHi;
	endfunction

	// gather inputs into one vector for the synchroniser
	assign rawIn[bbsw_pkg::IN_RUN]  = shutdownInput;
	assign rawIn[bbsw_pkg::IN_ABV]  = outAboveFlag;
	assign rawIn[bbsw_pkg::IN_VLO]  = vinLowFlag;
	assign rawIn[bbsw_pkg::IN_VHI]  = vinHighFlag;
	assign rawIn[bbsw_pkg::IN_PEAK] = peakCurrentFlag;
	assign rawIn[bbsw_pkg::IN_VAL]  = valleyCurrentFlag;
	assign rawIn[bbsw_pkg::IN_ZERO] = zeroCurrentFlag;
	assign rawIn[bbsw_pkg::IN_UP]   = startupDoneFlag;
	assign rawIn[bbsw_pkg::IN_OT]   = overTempFlag;

	// only the second sync stage is ever looked at
	assign flg = st_r.s2;
	// any stop condition wins over the sequencer
	assign run = flg[bbsw_pkg::IN_RUN] & ~flg[bbsw_pkg::IN_OT]
		& st_r.enable;
	assign busReq = cyc_i & stb_i;

	// next-state logic: sync, bus slave, sequencer, gates
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = rawIn;
		st_nxt.s2 = st_r.s1;
		want = 4'h0;

		// ack one cycle after the request, drop it the next
		st_nxt.ack = busReq & ~st_r.ack;
		st_nxt.rdata = 32'h0;
		if (busReq & ~st_r.ack)
		begin
			if (adr_i == bbsw_pkg::REG_CTRL)
			begin
				st_nxt.rdata[bbsw_pkg::CTRL_EN] = st_r.enable;
			end
			else if (adr_i == bbsw_pkg::REG_STATUS)
			begin
				st_nxt.rdata[bbsw_pkg::STAT_SEQ +: 3] = st_r.seq;
				st_nxt.rdata[bbsw_pkg::STAT_MODE +: 2] = st_r.mode;
				st_nxt.rdata[bbsw_pkg::STAT_GATES +: 4] = st_r.gates;
				st_nxt.rdata[bbsw_pkg::STAT_FLAGS +: 9] = flg;
			end
		end
		// the write lands on the edge where the master sees ack high,
		// so a master that aborts before ack never changes the enable
		if (busReq & st_r.ack & we_i & sel_i[0]
			& (adr_i == bbsw_pkg::REG_CTRL))
			st_nxt.enable = dat_i[bbsw_pkg::CTRL_EN];

		// off-time counter runs down on its own
		if (st_r.timer != 8'h00)
			st_nxt.timer = st_r.timer - 8'h01;

		if (!run)
		begin
			// shutdown, over-temperature or software stop
			st_nxt.seq = bbsw_pkg::SEQ_SLEEP;
			st_nxt.mode = bbsw_pkg::MODE_START;
			st_nxt.timer = 8'h00;
		end
		else
		begin
			unique case (st_r.seq)
				bbsw_pkg::SEQ_SLEEP:
				begin
					// stay idle while the output is high
					if (!flg[bbsw_pkg::IN_ABV])
					begin
						if (!flg[bbsw_pkg::IN_UP])
						begin
							st_nxt.mode = bbsw_pkg::MODE_START;
							st_nxt.seq = bbsw_pkg::SEQ_START_ON;
						end
						else
						begin
							st_nxt.mode = pickMode(flg[bbsw_pkg::IN_VLO],
								flg[bbsw_pkg::IN_VHI]);
							if (st_nxt.mode == bbsw_pkg::MODE_BUCK)
								st_nxt.seq = bbsw_pkg::SEQ_AD;
							else
								st_nxt.seq = bbsw_pkg::SEQ_AC;
						end
					end
				end
				bbsw_pkg::SEQ_START_ON:
				begin
					// valley and zero are not watched here
					if (flg[bbsw_pkg::IN_PEAK])
					begin
						st_nxt.seq = bbsw_pkg::SEQ_START_OFF;
						st_nxt.timer = START_OFF_CYC - 8'h01;
					end
				end
				bbsw_pkg::SEQ_START_OFF:
				begin
					if (st_r.timer == 8'h00)
					begin
						// past the threshold, hand over to normal modes
						if (flg[bbsw_pkg::IN_UP] | flg[bbsw_pkg::IN_ABV])
							st_nxt.seq = bbsw_pkg::SEQ_SLEEP;
						else
							st_nxt.seq = bbsw_pkg::SEQ_START_ON;
					end
				end
				bbsw_pkg::SEQ_AC:
				begin
					if (flg[bbsw_pkg::IN_PEAK])
					begin
						st_nxt.seq = bbsw_pkg::SEQ_AD;
						st_nxt.timer = FOUR_OFF_CYC - 8'h01;
					end
				end
				bbsw_pkg::SEQ_AD:
				begin
					if (st_r.mode == bbsw_pkg::MODE_FOUR)
					begin
						// fixed off-time, current flags do not end it
						if (st_r.timer == 8'h00)
							st_nxt.seq = bbsw_pkg::SEQ_BD;
					end
					else if (st_r.mode == bbsw_pkg::MODE_BUCK)
					begin
						if (flg[bbsw_pkg::IN_PEAK])
							st_nxt.seq = bbsw_pkg::SEQ_BD;
					end
					else if (flg[bbsw_pkg::IN_ABV])
					begin
						if (flg[bbsw_pkg::IN_ZERO])
							st_nxt.seq = bbsw_pkg::SEQ_SLEEP;
					end
					else if (flg[bbsw_pkg::IN_VAL])
					begin
						st_nxt.mode = pickMode(flg[bbsw_pkg::IN_VLO],
							flg[bbsw_pkg::IN_VHI]);
						st_nxt.seq = bbsw_pkg::SEQ_AC;
					end
				end
				bbsw_pkg::SEQ_BD:
				begin
					if (flg[bbsw_pkg::IN_ABV])
					begin
						if (flg[bbsw_pkg::IN_ZERO])
							st_nxt.seq = bbsw_pkg::SEQ_SLEEP;
					end
					else if (flg[bbsw_pkg::IN_VAL])
					begin
						st_nxt.mode = pickMode(flg[bbsw_pkg::IN_VLO],
							flg[bbsw_pkg::IN_VHI]);
						if (st_nxt.mode == bbsw_pkg::MODE_BUCK)
							st_nxt.seq = bbsw_pkg::SEQ_AD;
						else
							st_nxt.seq = bbsw_pkg::SEQ_AC;
					end
				end
			endcase
		end

		// switch pattern of the state being entered
		unique case (st_nxt.seq)
			bbsw_pkg::SEQ_SLEEP:
				want = 4'h0;
			bbsw_pkg::SEQ_START_ON, bbsw_pkg::SEQ_AC:
				want = 4'ha; // A+C
			bbsw_pkg::SEQ_START_OFF:
				want = 4'h4; // B only, D body diode carries
			bbsw_pkg::SEQ_AD:
				want = 4'h9; // A+D
			bbsw_pkg::SEQ_BD:
				want = 4'h5; // B+D
		endcase
		// D stays off until the output is up
		if (!flg[bbsw_pkg::IN_UP])
			want[bbsw_pkg::G_D] = 1'b0;

		// a switch turning on waits one cycle for its partner to open;
		// costs a cycle per phase change but never shorts a rail
		{st_nxt.gates[bbsw_pkg::G_A], st_nxt.gates[bbsw_pkg::G_B]} =
			pairGate(want[bbsw_pkg::G_A], want[bbsw_pkg::G_B],
				st_r.gates[bbsw_pkg::G_A],
				st_r.gates[bbsw_pkg::G_B]);
		{st_nxt.gates[bbsw_pkg::G_C], st_nxt.gates[bbsw_pkg::G_D]} =
			pairGate(want[bbsw_pkg::G_C], want[bbsw_pkg::G_D],
				st_r.gates[bbsw_pkg::G_C],
				st_r.gates[bbsw_pkg::G_D]);
	end

	// the single state register
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			st_r <= '0;
			st_r.seq <= bbsw_pkg::SEQ_SLEEP;
			st_r.mode <= bbsw_pkg::MODE_START;
			st_r.enable <= bbsw_pkg::CTRL_EN_RST;
		end
		else
			st_r <= st_nxt;
	end

	// outputs straight from the state register
	assign ack_o = st_r.ack;
	assign dat_o = st_r.rdata;
	assign gateA = st_r.gates[bbsw_pkg::G_A];
	assign gateB = st_r.gates[bbsw_pkg::G_B];
	assign gateC = st_r.gates[bbsw_pkg::G_C];
	assign gateD = st_r.gates[bbsw_pkg::G_D];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence sleepHeld;
		st_r.seq == bbsw_pkg::SEQ_SLEEP [*2];
	endsequence

	sequence fourOffDone;
		run && st_r.seq == bbsw_pkg::SEQ_AD
			&& st_r.mode == bbsw_pkg::MODE_FOUR && st_r.timer == 8'h00;
	endsequence

	sequence boostPeak;
		run && st_r.seq == bbsw_pkg::SEQ_AC
			&& st_r.mode == bbsw_pkg::MODE_BOOST && flg[bbsw_pkg::IN_PEAK];
	endsequence

	sleep_gates_off_a: assert property (
		sleepHeld |-> st_r.gates == 4'h0)
		else $error("gates on while asleep");

	pair_ab_excl_a: assert property (
		!(gateA && gateB))
		else $error("A and B on together");

	pair_cd_excl_a: assert property (
		!(gateC && gateD))
		else $error("C and D on together");

	boost_peak_ad_a: assert property (
		boostPeak |=> st_r.seq == bbsw_pkg::SEQ_AD
			&& st_r.timer == FOUR_OFF_CYC - 8'h01)
		else $error("boost peak did not enter A+D");

	four_off_bd_a: assert property (
		fourOffDone |=> st_r.seq == bbsw_pkg::SEQ_BD)
		else $error("off-time expiry did not give B+D");

	low_d_off_a: assert property (
		!flg[bbsw_pkg::IN_UP] |=> !gateD)
		else $error("D on below start-up threshold");

	shut_gates_off_a: assert property (
		!flg[bbsw_pkg::IN_RUN] |=> st_r.gates == 4'h0
			&& st_r.mode == bbsw_pkg::MODE_START)
		else $error("gates on during shutdown");

	hot_gates_off_a: assert property (
		flg[bbsw_pkg::IN_OT] |=> st_r.gates == 4'h0)
		else $error("gates on while over temperature");

	start_off_c_a: assert property (
		st_r.seq == bbsw_pkg::SEQ_START_OFF |-> !gateA && !gateD)
		else $error("wrong switches in start-up off-time");

	// an idle converter with the output low must start a pulse
	sequence wakeCall;
		run && st_r.seq == bbsw_pkg::SEQ_SLEEP && !flg[bbsw_pkg::IN_ABV];
	endsequence

	// last B+D of a burst once the output is back above threshold
	sequence lastPulse;
		run && st_r.seq == bbsw_pkg::SEQ_BD && flg[bbsw_pkg::IN_ABV];
	endsequence

	sleep_wake_a: assert property (
		wakeCall |=> st_r.seq != bbsw_pkg::SEQ_SLEEP)
		else $error("no wake with output low");

	zero_ends_a: assert property (
		lastPulse and flg[bbsw_pkg::IN_ZERO] |=>
			st_r.seq == bbsw_pkg::SEQ_SLEEP)
		else $error("zero current did not end the burst");

	valley_ignored_a: assert property (
		lastPulse and !flg[bbsw_pkg::IN_ZERO] |=>
			st_r.seq == bbsw_pkg::SEQ_BD)
		else $error("final pulse left before zero current");

	bus_ack_pulse_a: assert property (
		ack_o |=> !ack_o)
		else $error("ack held two cycles");

endmodule

// *** sim/power_stage_model.sv ***
`timescale 1ns/10ps
module power_stage_model #(
	parameter int PEAK_LVL = 10, // current level flagged as peak
	parameter int VAL_LVL  = 3   // current at or below this is valley
) (
	input  wire logic ref_clk,           // sequencer clock
	input  wire logic gateA,             // switch A on
	input  wire logic gateB,             // switch B on
	input  wire logic gateC,             // switch C on
	input  wire logic gateD,             // switch D on
	input  wire logic vinLowFlag,        // input well below output
	input  wire logic vinHighFlag,       // input well above output
	output logic      peakCurrentFlag,   // inductor at peak
	output logic      valleyCurrentFlag, // inductor at valley
	output logic      zeroCurrentFlag    // inductor at zero
);
	int cur = 0;

	// A+D stays flat near unity ratio, so only the timer can end it there
	always @(posedge ref_clk)
	begin
		if (gateA && (gateC || (gateD && vinHighFlag)))
			cur <= cur + 1;
		else if (gateA && gateD && !vinLowFlag)
			cur <= cur;
		else if (cur > 0)
			cur <= cur - 1;
	end

	assign peakCurrentFlag   = cur >= PEAK_LVL;
	assign valleyCurrentFlag = cur <= VAL_LVL;
	assign zeroCurrentFlag   = cur == 0;
endmodule

// *** sim/buck_boost_burst_switch_sequencer_tb_top.sv ***
`timescale 1ns/10ps
module buck_boost_burst_switch_sequencer_tb_top;
	localparam logic [7:0] FOUR = 8'h08;
	logic ref_clk = 1'b0, reset = 1'b1, run = 1'b0, above = 1'b0;
	logic vLo = 1'b0, vHi = 1'b0, upDone = 1'b0, hot = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic gA, gB, gC, gD, pk, vl, zr;
	wire logic [3:0] gv = {gA, gB, gC, gD};
	int failCount = 0, samplesChecked = 0, n;

	always #12.5 ref_clk = ~ref_clk;

	buck_boost_burst_switch_sequencer #(.FOUR_OFF_CYC(FOUR),
		.START_OFF_CYC(8'h04)) u_dut (.ref_clk(ref_clk), .reset(reset),
		.shutdownInput(run), .outAboveFlag(above), .vinLowFlag(vLo),
		.vinHighFlag(vHi), .peakCurrentFlag(pk), .valleyCurrentFlag(vl),
		.zeroCurrentFlag(zr), .startupDoneFlag(upDone), .overTempFlag(hot),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
		.sel_i(sel), .ack_o(ack), .dat_o(rdat), .gateA(gA), .gateB(gB),
		.gateC(gC), .gateD(gD));

	power_stage_model u_pwr (.ref_clk(ref_clk), .gateA(gA), .gateB(gB),
		.gateC(gC), .gateD(gD), .vinLowFlag(vLo), .vinHighFlag(vHi),
		.peakCurrentFlag(pk), .valleyCurrentFlag(vl), .zeroCurrentFlag(zr));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samplesChecked++;
		if (g !== e)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			failCount++;
		end
	endtask

	// single classic cycle; waits up to 50 cycles for ack, else counts a failure
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		sel <= 4'hf;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (ack !== 1'b1 && k < 50);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (k >= 50)
			chk(32'h0, 32'h1);
	endtask

	// three matching cycles in a row, so a one-cycle dead band never counts
	task automatic waitg(input logic [3:0] w);
		int k, m;
		k = 0;
		m = 0;
		while (m < 3 && k < 600)
		begin
			@(negedge ref_clk);
			k++;
			m = (gv === w) ? m + 1 : 0;
		end
		chk(32'(gv), 32'(w));
	endtask

	task automatic hold0(input int c);
		repeat (c)
		begin
			@(negedge ref_clk);
			chk(32'(gv), 32'h0);
		end
	endtask

	task automatic mode(input logic [1:0] m);
		wb(1'b0, bbsw_pkg::REG_STATUS, 32'h0);
		chk(32'(q[bbsw_pkg::STAT_MODE +: 2]), 32'(m));
	endtask

	task automatic conclude;
		if (failCount == 0 && samplesChecked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// cross-conduction and masked D checked every cycle
	always @(negedge ref_clk)
		if (!reset)
			chk(32'({gA & gB, gC & gD, gD & ~upDone}), 32'h0);

	initial
	begin
		#(25 * 40000);
		failCount++;
		conclude();
	end

	initial
	begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		wb(1'b0, bbsw_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h1);
		wb(1'b0, bbsw_pkg::REG_STATUS, 32'h0);
		chk(32'({q[11:8], q[5:0]}), 32'h0);
		wb(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
		hold0(10);
		@(posedge ref_clk) run <= 1'b1;
		waitg(4'b1010);
		waitg(4'b0100);
		mode(bbsw_pkg::MODE_START);
		@(posedge ref_clk) {upDone, vLo} <= 2'b11;
		waitg(4'b1001);
		mode(bbsw_pkg::MODE_BOOST);
		waitg(4'b1010);
		@(posedge ref_clk) above <= 1'b1;
		waitg(4'b0000);
		hold0(20);
		@(posedge ref_clk) {above, vLo} <= 2'b00;
		waitg(4'b1001);
		n = 3;
		while (gv === 4'b1001 && n < 200)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n >= FOUR && n <= FOUR + 2), 32'h1);
		waitg(4'b0101);
		mode(bbsw_pkg::MODE_FOUR);
		@(posedge ref_clk) {above, vHi} <= 2'b11;
		waitg(4'b0000);
		@(posedge ref_clk) above <= 1'b0;
		waitg(4'b1001);
		mode(bbsw_pkg::MODE_BUCK);
		waitg(4'b0101);
		@(posedge ref_clk) hot <= 1'b1;
		waitg(4'b0000);
		hold0(10);
		@(posedge ref_clk) hot <= 1'b0;
		waitg(4'b1001);
		wb(1'b1, bbsw_pkg::REG_CTRL, 32'h0);
		waitg(4'b0000);
		hold0(10);
		wb(1'b0, bbsw_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, bbsw_pkg::REG_CTRL, 32'h1);
		@(posedge ref_clk) run <= 1'b0;
		waitg(4'b0000);
		hold0(5);
		mode(bbsw_pkg::MODE_START);
		conclude();
	end
endmodule
